// >>> rtl/mlf_policy.sv
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Bits 10-7 pick retry wait: 1h is 500 ms, 2h-Fh 1-14 s.
// - Codes 0h-3h latch lock fault, assert pin; tristate, recirc, HS or LS brake.
// - High-side brake turns all three high FETs on; low-side all three low.
// - Code 6h auto-clears after each wait up to limit, high-side brake, pin asserted.
// - Code 8h only asserts the fault pin, outputs left alone.
// - Codes 9h-Fh disable lock detection: no fault, no action.
// - Bit 2 enables the position-detect timeout fault.
// - Bit 1 enables the position-detect frequency fault.
// - Bit 0 enables reporting of current and speed loop saturation.
module mlf_policy #(
	parameter int MS_CYCLES = mlf_pkg::MS_CYCLES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	// Detector inputs, same clock
	input wire logic lock_detect,
	input wire logic motor_running,
	input wire logic pos_timeout_evt,
	input wire logic pos_freq_evt,
	input wire logic cur_loop_sat,
	input wire logic spd_loop_sat,
	// Power stage control
	output logic override_active,
	output logic [2:0] hs_on,
	output logic [2:0] ls_on,
	output logic phase_tristate,
	output logic phase_recirc,
	// Fault reporting
	output logic fault_indicator_n,
	output logic pos_timeout_fault,
	output logic pos_freq_fault,
	output logic cur_sat_flag,
	output logic spd_sat_flag,
	output logic irq
);
	logic [mlf_pkg::CFG_W-1:0] cfg_r;
	logic [mlf_pkg::RETRY_LIM_W-1:0] retry_limit_r;
	logic [mlf_pkg::RETRY_LIM_W-1:0] retry_cnt_r;
	logic [mlf_pkg::EV_W-1:0] stat_r;
	logic [mlf_pkg::EV_W-1:0] stat_nxt;
	logic [mlf_pkg::EV_W-1:0] irq_en_r;
	logic [mlf_pkg::EV_W-1:0] events;
	logic [3:0] fault_mode_r;
	logic [3:0] mode_nxt;
	logic [3:0] lock_sel;
	logic [3:0] retry_ivl;
	logic [mlf_pkg::MS_CNT_W-1:0] ms_cnt_r;
	logic [mlf_pkg::MS_CNT_W-1:0] ms_target;
	logic sw_clear;
	logic counting;
	logic ms_tick;
	logic timer_done;
	logic good_run;
	logic retry_mode;
	mlf_pkg::mlf_state_t state_r;
	mlf_pkg::mlf_state_t state_nxt;

	assign lock_sel = cfg_r[mlf_pkg::LOCK_SEL_LSB +: mlf_pkg::LOCK_SEL_W];
	assign retry_ivl = cfg_r[mlf_pkg::RETRY_IVL_LSB +: mlf_pkg::RETRY_IVL_W];
	assign sw_clear = wr_en && (addr == mlf_pkg::REG_CTRL) && wdata[mlf_pkg::SW_CLEAR_BIT];
	assign retry_mode = (lock_sel >= mlf_pkg::LOCK_RETRY_MIN) &&
		(lock_sel <= mlf_pkg::LOCK_RETRY_MAX);

	// retry wait in ms
	// Reserved code 0h is treated like 1h so the wait is never zero
	always_comb begin
		if (retry_ivl <= 4'h1) begin
			ms_target = mlf_pkg::MS_CNT_W'(mlf_pkg::RETRY_SHORT_MS);
		end else begin
			ms_target = mlf_pkg::MS_CNT_W'((32'(retry_ivl) - 32'd1) * mlf_pkg::RETRY_STEP_MS);
		end
	end

	// Millisecond timer runs while waiting, or while a spent budget is healing
	assign good_run = (state_r == mlf_pkg::ST_RUN) && motor_running && !lock_detect &&
		(retry_cnt_r != '0);
	assign counting = (state_r == mlf_pkg::ST_RETRY_WAIT) || good_run;
	assign timer_done = counting && (ms_cnt_r >= ms_target);

	mlf_tick_div #(
		.DIV(MS_CYCLES)
	) u_ms_div (
		.mclk(mclk),
		.resetn(resetn),
		.run(counting),
		.tick(ms_tick)
	);

	// Elapsed ms counter
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			ms_cnt_r <= '0;
		end else if (!counting || timer_done) begin
			ms_cnt_r <= '0;
		end else if (ms_tick) begin
			ms_cnt_r <= ms_cnt_r + mlf_pkg::MS_CNT_W'(1);
		end
	end

	// Lock fault state machine
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			mlf_pkg::ST_RUN: begin
				if (lock_detect) begin
					if (lock_sel <= mlf_pkg::LOCK_LATCH_MAX) begin
						state_nxt = mlf_pkg::ST_LATCHED;
					end else if (retry_mode) begin
						if (retry_cnt_r < retry_limit_r) begin
							state_nxt = mlf_pkg::ST_RETRY_WAIT;
						end else begin
							state_nxt = mlf_pkg::ST_LATCHED;
						end
					end else if (lock_sel == mlf_pkg::LOCK_REPORT) begin
						state_nxt = mlf_pkg::ST_REPORT;
					end
				end
			end
			mlf_pkg::ST_RETRY_WAIT: begin
				if (timer_done || sw_clear) begin
					state_nxt = mlf_pkg::ST_RUN;
				end
			end
			mlf_pkg::ST_LATCHED: begin
				if (sw_clear) begin
					state_nxt = mlf_pkg::ST_RUN;
				end
			end
			mlf_pkg::ST_REPORT: begin
				if (!lock_detect || sw_clear) begin
					state_nxt = mlf_pkg::ST_RUN;
				end
			end
			default: begin
				state_nxt = mlf_pkg::ST_RUN;
			end
		endcase
	end

	// Response code is frozen at fault entry; a rewrite mid-fault waits
	assign mode_nxt = (state_r == mlf_pkg::ST_RUN) ? lock_sel : fault_mode_r;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			state_r <= mlf_pkg::ST_RUN;
			fault_mode_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			fault_mode_r <= mode_nxt;
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			retry_cnt_r <= '0;
		end else if (sw_clear || (good_run && timer_done)) begin
			retry_cnt_r <= '0;
		end else if (state_r == mlf_pkg::ST_RUN && state_nxt == mlf_pkg::ST_RETRY_WAIT) begin
			retry_cnt_r <= retry_cnt_r + mlf_pkg::RETRY_LIM_W'(1);
		end
	end

	// Power stage override, registered from the next state
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			override_active <= 1'b0;
			hs_on <= 3'h0;
			ls_on <= 3'h0;
			phase_tristate <= 1'b0;
			phase_recirc <= 1'b0;
			fault_indicator_n <= 1'b1;
		end else begin
			// pin asserted in every fault state
			fault_indicator_n <= (state_nxt == mlf_pkg::ST_RUN);
			override_active <= 1'b0;
			hs_on <= 3'h0;
			ls_on <= 3'h0;
			phase_tristate <= 1'b0;
			phase_recirc <= 1'b0;
			if (state_nxt == mlf_pkg::ST_LATCHED || state_nxt == mlf_pkg::ST_RETRY_WAIT) begin
				override_active <= 1'b1;
				case (mode_nxt[1:0])
					mlf_pkg::ACT_TRISTATE: phase_tristate <= 1'b1;
					mlf_pkg::ACT_RECIRC: phase_recirc <= 1'b1;
					mlf_pkg::ACT_HS_BRAKE: hs_on <= 3'h7;
					mlf_pkg::ACT_LS_BRAKE: ls_on <= 3'h7;
					default: phase_tristate <= 1'b1;
				endcase
			end
		end
	end

	// Gated fault and saturation indications
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pos_timeout_fault <= 1'b0;
			pos_freq_fault <= 1'b0;
			cur_sat_flag <= 1'b0;
			spd_sat_flag <= 1'b0;
		end else begin
			pos_timeout_fault <= pos_timeout_evt && cfg_r[mlf_pkg::POS_TMO_EN_BIT];
			pos_freq_fault <= pos_freq_evt && cfg_r[mlf_pkg::POS_FRQ_EN_BIT];
			cur_sat_flag <= cur_loop_sat && cfg_r[mlf_pkg::SAT_EN_BIT];
			spd_sat_flag <= spd_loop_sat && cfg_r[mlf_pkg::SAT_EN_BIT];
		end
	end

	// Event sources for the sticky status
	always_comb begin
		events = '0;
		events[mlf_pkg::EV_LOCK] = (state_r == mlf_pkg::ST_RUN) &&
			(state_nxt != mlf_pkg::ST_RUN);
		events[mlf_pkg::EV_EXHAUST] = (state_r == mlf_pkg::ST_RUN) && retry_mode &&
			(state_nxt == mlf_pkg::ST_LATCHED);
		events[mlf_pkg::EV_POS_TMO] = pos_timeout_evt && cfg_r[mlf_pkg::POS_TMO_EN_BIT];
		events[mlf_pkg::EV_POS_FRQ] = pos_freq_evt && cfg_r[mlf_pkg::POS_FRQ_EN_BIT];
		events[mlf_pkg::EV_SAT] = (cur_loop_sat || spd_loop_sat) && cfg_r[mlf_pkg::SAT_EN_BIT];
	end

	// A new event beats a clear landing in the same cycle
	always_comb begin
		stat_nxt = stat_r;
		if (wr_en && addr == mlf_pkg::REG_IRQ_CLR) begin
			stat_nxt = stat_nxt & ~wdata[mlf_pkg::EV_W-1:0];
		end
		stat_nxt = stat_nxt | events;
	end

	// Sticky status and level interrupt
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			stat_r <= '0;
			irq <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			irq <= |(stat_nxt & irq_en_r);
		end
	end

	// Register writes
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cfg_r <= mlf_pkg::CFG_RESET;
			irq_en_r <= '0;
			retry_limit_r <= mlf_pkg::RETRY_LIM_RESET;
		end else if (wr_en) begin
			case (addr)
				mlf_pkg::REG_CFG: cfg_r <= wdata[mlf_pkg::CFG_W-1:0];
				mlf_pkg::REG_IRQ_EN: irq_en_r <= wdata[mlf_pkg::EV_W-1:0];
				mlf_pkg::REG_CTRL: begin
					retry_limit_r <= wdata[mlf_pkg::RETRY_LIM_LSB +: mlf_pkg::RETRY_LIM_W];
				end
				default: begin
				end
			endcase
		end
	end

	// Read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 32'h0000_0000;
		end else if (rd_en) begin
			case (addr)
				mlf_pkg::REG_CFG: rdata <= 32'(cfg_r);
				mlf_pkg::REG_IRQ_STAT: rdata <= 32'(stat_r);
				mlf_pkg::REG_IRQ_EN: rdata <= 32'(irq_en_r);
				mlf_pkg::REG_CTRL: rdata <= 32'(retry_limit_r);
				mlf_pkg::REG_STATE: rdata <= {24'h00_0000, 1'b0, retry_cnt_r, 2'h0, state_r};
				default: rdata <= 32'h0000_0000;
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);

	a_latch_pin: assert property (
		state_r == mlf_pkg::ST_LATCHED |-> !fault_indicator_n && override_active)
		else $error("latched fault without pin or override");
	a_latch_entry: assert property (
		state_r == mlf_pkg::ST_RUN && lock_detect && lock_sel <= mlf_pkg::LOCK_LATCH_MAX
		|=> state_r == mlf_pkg::ST_LATCHED [*2] or (state_r == mlf_pkg::ST_LATCHED ##1 sw_clear))
		else $error("latching code did not latch");
	a_brake_group: assert property (
		hs_on != 3'h0 |-> hs_on == 3'h7 && ls_on == 3'h0 && !fault_indicator_n)
		else $error("high-side brake partial or overlapping");
	a_retry_limit: assert property (
		state_r == mlf_pkg::ST_RUN && lock_detect && retry_mode && retry_cnt_r >= retry_limit_r
		|=> state_r == mlf_pkg::ST_LATCHED)
		else $error("retry budget exceeded without latch");
	a_retry_clear: assert property (
		state_r == mlf_pkg::ST_RETRY_WAIT && timer_done |=> state_r == mlf_pkg::ST_RUN
		&& fault_indicator_n)
		else $error("retry wait did not clear");
	a_wait_bound: assert property (
		state_r == mlf_pkg::ST_RETRY_WAIT |-> ms_cnt_r <= ms_target)
		else $error("retry timer overran interval");
	a_report_only: assert property (
		state_r == mlf_pkg::ST_REPORT |-> !fault_indicator_n && !override_active
		&& hs_on == 3'h0 && ls_on == 3'h0 && !phase_tristate && !phase_recirc)
		else $error("report mode drove outputs");
	a_lock_disabled: assert property (
		state_r == mlf_pkg::ST_RUN && lock_sel > mlf_pkg::LOCK_REPORT |=> fault_indicator_n)
		else $error("disabled detection raised fault");
	a_pos_timeout: assert property (
		pos_timeout_fault |-> $past(cfg_r[mlf_pkg::POS_TMO_EN_BIT]) && $past(pos_timeout_evt))
		else $error("timeout fault while disabled");
	a_pos_freq: assert property (
		pos_freq_evt && cfg_r[mlf_pkg::POS_FRQ_EN_BIT] |=> pos_freq_fault)
		else $error("enabled frequency fault not raised");
	a_sat_gate: assert property (
		!cfg_r[mlf_pkg::SAT_EN_BIT] |=> !cur_sat_flag && !spd_sat_flag)
		else $error("saturation reported while disabled");
	a_cnt_reset: assert property (
		sw_clear |=> retry_cnt_r == '0 && (state_r == mlf_pkg::ST_RUN || $past(lock_detect)))
		else $error("software clear left retry count");

	c_latch: cover property (state_r == mlf_pkg::ST_LATCHED ##1 state_r == mlf_pkg::ST_RUN);
	c_retry: cover property (state_r == mlf_pkg::ST_RETRY_WAIT && timer_done);
	c_report: cover property (state_r == mlf_pkg::ST_REPORT);
	c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// >>> pkg/mlf_pkg.sv
package mlf_pkg;
	// Register byte addresses
	localparam logic [7:0] REG_CFG = 8'h00;
	localparam logic [7:0] REG_IRQ_STAT = 8'h04;
	localparam logic [7:0] REG_IRQ_EN = 8'h08;
	localparam logic [7:0] REG_IRQ_CLR = 8'h0C;
	localparam logic [7:0] REG_CTRL = 8'h10;
	localparam logic [7:0] REG_STATE = 8'h14;

	// Fault protection settings fields
	localparam int RETRY_IVL_LSB = 7;
	localparam int RETRY_IVL_W = 4;
	localparam int LOCK_SEL_LSB = 3;
	localparam int LOCK_SEL_W = 4;
	localparam int POS_TMO_EN_BIT = 2;
	localparam int POS_FRQ_EN_BIT = 1;
	localparam int SAT_EN_BIT = 0;
	localparam int CFG_W = 11;
	localparam logic [CFG_W-1:0] CFG_RESET = 11'h000;

	// Control register fields
	localparam int RETRY_LIM_LSB = 0;
	localparam int RETRY_LIM_W = 3;
	localparam int SW_CLEAR_BIT = 8;
	localparam logic [RETRY_LIM_W-1:0] RETRY_LIM_RESET = 3'h3;

	// Interrupt status bit positions
	localparam int EV_LOCK = 0;
	localparam int EV_EXHAUST = 1;
	localparam int EV_POS_TMO = 2;
	localparam int EV_POS_FRQ = 3;
	localparam int EV_SAT = 4;
	localparam int EV_W = 5;

	// Lock response codes
	localparam logic [3:0] LOCK_LATCH_MAX = 4'h3;
	localparam logic [3:0] LOCK_RETRY_MIN = 4'h4;
	localparam logic [3:0] LOCK_RETRY_MAX = 4'h7;
	localparam logic [3:0] LOCK_REPORT = 4'h8;

	// Output action in low two bits of a response code
	localparam logic [1:0] ACT_TRISTATE = 2'h0;
	localparam logic [1:0] ACT_RECIRC = 2'h1;
	localparam logic [1:0] ACT_HS_BRAKE = 2'h2;
	localparam logic [1:0] ACT_LS_BRAKE = 2'h3;

	// Timing
	localparam int CLK_HZ = 40000000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int RETRY_SHORT_MS = 500;
	localparam int RETRY_STEP_MS = 1000;
	localparam int MS_CNT_W = 14;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_RETRY_WAIT,
		ST_LATCHED,
		ST_REPORT
	} mlf_state_t;
endpackage

// >>> rtl/mlf_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module mlf_tick_div #(
	parameter int DIV = 40000
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Control
	input wire logic run,
	// Enable pulse out
	output logic tick
);
	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_r;

	// Counter restarts whenever run drops, so each interval starts full
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else if (cnt_r == LAST) begin
			cnt_r <= '0;
			tick <= 1'b1;
		end else begin
			cnt_r <= cnt_r + CW'(1);
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> dv/mlf_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module mlf_motor_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// Bench control: rotor held still
	input wire logic stall,
	// Power stage commands
	input wire logic override_active,
	input wire logic [2:0] hs_on,
	input wire logic [2:0] ls_on,
	// Motor feedback
	output logic lock_detect,
	output logic motor_running
);
	// Lock detector lags the mechanical stall by one cycle, as a real filter would
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			lock_detect <= 1'b0;
			motor_running <= 1'b0;
		end else begin
			lock_detect <= stall;
			// Any braking or hi-Z command stops the rotor
			motor_running <= !stall && !override_active && !(|hs_on) && !(|ls_on);
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb_motor_lock_fault_policy.sv
`timescale 1ns/1ps
`default_nettype none
module tb_motor_lock_fault_policy;
	logic mclk = 1'b0, resetn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, stall = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, v, rdata;
	logic [3:0] evt = 4'h0, r;
	logic lock_detect, motor_running, override_active, phase_tristate, phase_recirc, irq;
	logic fault_indicator_n, pos_timeout_fault, pos_freq_fault, cur_sat_flag, spd_sat_flag;
	logic [2:0] hs_on, ls_on;
	int n_errors = 0, checked = 0, cycle = 0, t0, d, e, ivl;
	wire logic [9:0] pins_now = {fault_indicator_n, override_active, hs_on, ls_on,
		phase_tristate, phase_recirc};

	// 40 MHz clock
	always #12.5 mclk = ~mclk;

	// Short ms tick keeps retry waits to a few thousand cycles
	mlf_policy #(.MS_CYCLES(4)) i_dut (.mclk(mclk), .resetn(resetn), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.lock_detect(lock_detect), .motor_running(motor_running),
		.pos_timeout_evt(evt[3]), .pos_freq_evt(evt[2]), .cur_loop_sat(evt[1]),
		.spd_loop_sat(evt[0]), .override_active(override_active), .hs_on(hs_on),
		.ls_on(ls_on), .phase_tristate(phase_tristate), .phase_recirc(phase_recirc),
		.fault_indicator_n(fault_indicator_n), .pos_timeout_fault(pos_timeout_fault),
		.pos_freq_fault(pos_freq_fault), .cur_sat_flag(cur_sat_flag),
		.spd_sat_flag(spd_sat_flag), .irq(irq));

	mlf_motor_model i_motor (.mclk(mclk), .resetn(resetn), .stall(stall),
		.override_active(override_active), .hs_on(hs_on), .ls_on(ls_on),
		.lock_detect(lock_detect), .motor_running(motor_running));

	// Expected pins {pin_n, override, hs, ls, tri, recirc} for a response code
	function automatic logic [9:0] pins(input int f, input int c);
		if (f == 0) return 10'h200;
		if (c == 8) return 10'h000;
		case (c % 4)
			0: return 10'h102;
			1: return 10'h101;
			2: return 10'h1E0;
			default: return 10'h11C;
		endcase
	endfunction

	task automatic summarize();
		$display("errors=%0d checks=%0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_pins(input logic [9:0] got, input logic [9:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t pins got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dv);
		@(posedge mclk);
		addr <= a;
		wdata <= dv;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 q = rdata;
	endtask

	// Bounded wait for the fault pin to reach a level
	task automatic wait_pin(input logic lv);
		int k;
		k = 0;
		while (fault_indicator_n !== lv && k < 9000) begin
			@(posedge mclk);
			#1 k++;
		end
		cmp_reg({31'h0, fault_indicator_n}, {31'h0, lv});
	endtask

	task automatic hit(input int c);
		@(posedge mclk);
		stall <= 1'b1;
		wait_pin(1'b0);
		cmp_pins(pins_now, pins(1, c));
	endtask

	// Cycle count and hang guard
	always @(posedge mclk) begin
		cycle++;
		if (cycle == 30000) begin
			n_errors++;
			summarize();
		end
	end

	initial begin
		void'($urandom(54));
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		#1 cmp_pins(pins_now, 10'h200);
		// Reset values, unmapped and write-only places, unused high bits
		rd(mlf_pkg::REG_CFG, v);
		cmp_reg(v, 32'h0);
		rd(mlf_pkg::REG_CTRL, v);
		cmp_reg(v, 32'h3);
		rd(8'hFC, v);
		cmp_reg(v, 32'h0);
		rd(mlf_pkg::REG_IRQ_CLR, v);
		cmp_reg(v, 32'h0);
		wr(mlf_pkg::REG_CFG, 32'hFFFFFFFF);
		rd(mlf_pkg::REG_CFG, v);
		cmp_reg(v, 32'h7FF);
		// Every enable combination, lock detection off
		for (int i = 0; i < 8; i++) begin
			wr(mlf_pkg::REG_CFG, 32'h48 | i);
			r = 4'($urandom());
			@(posedge mclk);
			evt <= r;
			@(posedge mclk);
			evt <= 4'h0;
			#1 cmp_reg({pos_timeout_fault, pos_freq_fault, cur_sat_flag, spd_sat_flag},
				{r[3] & i[2], r[2] & i[1], r[1] & i[0], r[0] & i[0]});
		end
		// Latching codes, interrupt masked for the first
		for (int c = 0; c < 4; c++) begin
			wr(mlf_pkg::REG_IRQ_EN, (c == 0) ? 32'h0 : 32'h1F);
			wr(mlf_pkg::REG_CFG, 32'h80 | (c << 3));
			hit(c);
			cmp_reg({31'h0, irq}, {31'h0, c != 0});
			rd(mlf_pkg::REG_IRQ_STAT, v);
			cmp_reg(v & 32'h1, 32'h1);
			@(posedge mclk);
			stall <= 1'b0;
			wr(mlf_pkg::REG_IRQ_CLR, 32'h1F);
			wr(mlf_pkg::REG_CTRL, 32'h103);
			@(posedge mclk);
			#1 cmp_pins(pins_now, 10'h200);
			cmp_reg({31'h0, irq}, 32'h0);
		end
		// Report only clears when the lock goes away
		wr(mlf_pkg::REG_CFG, 32'h40);
		hit(8);
		@(posedge mclk);
		stall <= 1'b0;
		wait_pin(1'b1);
		cmp_pins(pins_now, 10'h200);
		// Disabled codes ignore the detector
		for (int c = 9; c < 16; c++) begin
			wr(mlf_pkg::REG_CFG, c << 3);
			@(posedge mclk);
			stall <= 1'b1;
			repeat (4) @(posedge mclk);
			#1 cmp_pins(pins_now, 10'h200);
			@(posedge mclk);
			stall <= 1'b0;
		end
		// Retry codes with a budget of one, stall held so the second lock latches
		wr(mlf_pkg::REG_CTRL, 32'h1);
		for (int c = 4; c < 8; c++) begin
			ivl = (c == 7) ? 2 : 1;
			e = (ivl == 1) ? 2000 : 4000;
			wr(mlf_pkg::REG_CFG, (ivl << 7) | (c << 3));
			hit(c);
			t0 = cycle;
			wait_pin(1'b1);
			d = cycle - t0;
			cmp_reg({31'h0, d >= e - 6 && d <= e + 6}, 32'h1);
			wait_pin(1'b0);
			cmp_pins(pins_now, pins(1, c));
			rd(mlf_pkg::REG_IRQ_STAT, v);
			cmp_reg(v & 32'h2, 32'h2);
			rd(mlf_pkg::REG_STATE, v);
			cmp_reg(v, 32'h12);
			@(posedge mclk);
			stall <= 1'b0;
			wr(mlf_pkg::REG_IRQ_CLR, 32'h1F);
			wr(mlf_pkg::REG_CTRL, 32'h101);
			rd(mlf_pkg::REG_STATE, v);
			cmp_reg(v, 32'h0);
		end
		// Fault-free running for one interval restores the retry budget
		wr(mlf_pkg::REG_CFG, 32'hA0);
		hit(4);
		@(posedge mclk);
		stall <= 1'b0;
		wait_pin(1'b1);
		rd(mlf_pkg::REG_STATE, v);
		cmp_reg(v, 32'h10);
		repeat (2020) @(posedge mclk);
		rd(mlf_pkg::REG_STATE, v);
		cmp_reg(v, 32'h0);
		summarize();
	end
endmodule
`default_nettype wire
